/* File: common/mio_cfg.svh */
/*
 * constants of the multi-lane serial interface front end: register offsets,
 * reset values, field positions, serial command codes and frame bit counts.
 * assumes it is included by bare name before the package is used.
 */
//
// Overview of operation
// [R01] serial clock may idle low or high
// [R02] both clock modes work in every protocol
// [R03] output lanes driven only while selected
// [R04] master keeps protect and hold pins defined
// [R05] extended protocol default, command on lane0
// [R06] volatile bit6=0, bit7=1 selects two lanes
// [R07] volatile bit7=0 selects four lanes
// [R08] volatile protocol lost at power-on
// [R09] rescue or new write restores default
// [R10] nonvolatile bit2=0 boots two-lane protocol
// [R11] nonvolatile choice persists until bit set; here presetn also reloads RST_NVCFG
// [R12] nonvolatile bit3=0 boots four-lane protocol
// [R13] six user registers are reachable
// [R14] hidden working configuration governs operation; here it is readable at OFF_PROTO
// [R15] working configuration loaded from nonvolatile at boot
// [R16] volatile writes copied to working configuration
// [R17] sample on rising, drive from falling
// [R18] four-lane selection beats two-lane selection
`ifndef MIO_CFG_SVH
`define MIO_CFG_SVH

// register byte offsets
`define OFF_STATUS 8'h00
`define OFF_NVCFG 8'h04
`define OFF_VCFG 8'h08
`define OFF_EVCFG 8'h0C
`define OFF_FLAG 8'h10
`define OFF_LOCK 8'h14
`define OFF_CTRL 8'h18
`define OFF_PROTO 8'h1C

// reset values
`define RST_STATUS 8'h00
`define RST_NVCFG 16'hFFFF
`define RST_VCFG 8'hFB
`define RST_EVCFG 8'hFF
`define RST_FLAG 8'h80
`define RST_LOCK 8'h00

// field positions
`define NV_DUAL_BIT 2
`define NV_QUAD_BIT 3
`define EV_DUAL_BIT 6
`define EV_QUAD_BIT 7
`define CTRL_BOOT_BIT 0
`define CTRL_RESCUE_BIT 1

// serial command codes
`define OP_WR_VCFG 8'h81
`define OP_WR_EVCFG 8'h61
`define OP_RD_STATUS 8'h05
`define OP_RD_VCFG 8'h85
`define OP_RD_EVCFG 8'h65
`define OP_RD_FLAG 8'h70

// frame bit counts
`define CMD_BITS 5'd8
`define WR_BITS 5'd16
`define OVER_BITS 5'd17

`endif

/* File: common/mio_pkg.sv */
/*
 * types of the multi-lane serial interface front end.
 * assumes nothing beyond a SystemVerilog compiler.
 */
package mio_pkg;

	// lane protocol in force
	typedef enum logic [1:0] {
		PROTO_EXT = 2'b00,
		PROTO_DUAL = 2'b01,
		PROTO_QUAD = 2'b10
	} proto_t;

	// position inside a serial frame
	typedef enum logic [1:0] {
		PH_IDLE = 2'b00,
		PH_CMD = 2'b01,
		PH_WR = 2'b10,
		PH_RD = 2'b11
	} phase_t;

endpackage

/* File: rtl/pin_sync.sv */
/*
 * three-flop pin synchroniser: a level is accepted once the second and
 * third flops agree. assumes pins are asynchronous to clk.
 */
`timescale 1ns/1ns

module pin_sync #(
	parameter int W = 6,
	parameter logic [5:0] RST = 6'h01
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pins and filtered levels
	input wire logic [W-1:0] pin_in,
	output logic [W-1:0] level
);

	logic [W-1:0] s1; // first stage, read only by s2
	logic [W-1:0] s2; // second stage
	logic [W-1:0] s3; // third stage

	////////////////////////////////////////////////////////////////////////
	genvar i;
	generate
		for (i = 0; i < W; i++) begin : g_bit
			// three stages, level follows when stages two and three agree
			always_ff @(posedge clk or negedge rst_n) begin
				if (!rst_n) begin
					s1[i] <= RST[i];
					s2[i] <= RST[i];
					s3[i] <= RST[i];
					level[i] <= RST[i];
				end else begin
					s1[i] <= pin_in[i];
					s2[i] <= s1[i];
					s3[i] <= s2[i];
					if (s2[i] == s3[i]) begin
						level[i] <= s3[i];
					end
				end
			end
		end
	endgenerate

endmodule // pin_sync

/* File: rtl/multi_io_protocol_config.sv */
/*
 * multi-lane serial interface front end: apb register file, working
 * configuration, lane protocol selection and a small serial command engine.
 * assumes the serial clock half period spans several pclk periods.
 */
`timescale 1ns/1ns
`include "mio_cfg.svh"

module multi_io_protocol_config (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// serial pins
	input wire logic cs_n_pin,
	input wire logic sclk_pin,
	input wire logic [3:0] lane_in,
	output logic [3:0] lane_out,
	output logic [3:0] lane_oe,
	// protocol in force
	output mio_pkg::proto_t active_proto
);
	import mio_pkg::*;

	////////////////////////////////////////////////////////////////////////
	// declarations
	logic [5:0] pin_level; // {lanes, sclk, cs_n} after synchroniser
	logic cs_n_s; // filtered chip select
	logic sclk_s; // filtered serial clock
	logic [3:0] lane_s; // filtered lanes
	logic sclk_prev; // serial clock one cycle back
	logic cs_prev; // selection one cycle back
	logic selected; // device selected
	logic rise; // rising serial edge while selected
	logic fall; // falling serial edge while selected
	logic frame_end; // selection just released
	logic [7:0] status_reg; // status register
	logic [15:0] nvcfg; // nonvolatile configuration
	logic [7:0] vcfg; // volatile configuration
	logic [7:0] evcfg; // enhanced volatile configuration
	logic [7:0] flag_reg; // flag status register
	logic [7:0] lock_reg; // lock register
	proto_t proto; // working configuration: protocol
	logic boot_pend; // working configuration reload pending
	phase_t phase; // frame phase
	logic [4:0] bit_cnt; // bits taken in this frame
	logic [15:0] in_shift; // received bits
	logic [7:0] out_shift; // bits to present
	logic [4:0] step; // bits per serial edge
	logic [15:0] next_shift; // in_shift after this edge
	logic [4:0] next_cnt; // bit_cnt after this edge
	logic cmd_done; // command byte completes now
	logic [7:0] rd_value; // register chosen by read command
	logic setup; // apb setup cycle
	logic apb_wr; // apb write takes effect
	logic hit; // apb address mapped
	logic [31:0] rd_mux; // apb read value
	logic ser_v_wr; // serial volatile write completes
	logic ser_ev_wr; // serial enhanced write completes
	logic v_wr; // any volatile write
	logic ev_wr; // any enhanced write
	logic [7:0] v_wdata; // volatile write data
	logic [7:0] ev_wdata; // enhanced write data
	logic boot_req; // software reboot request
	logic rescue_req; // software rescue request

	////////////////////////////////////////////////////////////////////////
	// pin synchroniser
	pin_sync #(
		.W(6),
		.RST(6'h01)
	) u_sync (
		.clk(pclk),
		.rst_n(presetn),
		.pin_in({lane_in, sclk_pin, cs_n_pin}),
		.level(pin_level)
	);

	assign cs_n_s = pin_level[0];
	assign sclk_s = pin_level[1];
	assign lane_s = pin_level[5:2];
	assign selected = ~cs_n_s;

	// edge history of filtered serial clock and selection
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sclk_prev <= 1'b0;
			cs_prev <= 1'b0;
		end else begin
			sclk_prev <= sclk_s;
			cs_prev <= selected;
		end
	end

	// [R01] idle level free
	// edges only counted while selected, so idle level never matters
	assign rise = selected & sclk_s & ~sclk_prev;
	assign fall = selected & ~sclk_s & sclk_prev;
	assign frame_end = cs_prev & ~selected;

	////////////////////////////////////////////////////////////////////////
	// lane width and receive shifter
	// [R02] width per protocol
	always_comb begin
		step = 5'd1;
		next_shift = {in_shift[14:0], lane_s[0]};
		unique case (proto)
			// [R05] extended command on lane0
			PROTO_EXT: begin
				step = 5'd1;
				next_shift = {in_shift[14:0], lane_s[0]};
			end
			// [R06] two lanes
			PROTO_DUAL: begin
				step = 5'd2;
				next_shift = {in_shift[13:0], lane_s[1:0]};
			end
			// [R07] four lanes
			PROTO_QUAD: begin
				step = 5'd4;
				next_shift = {in_shift[11:0], lane_s};
			end
			default: begin
				step = 5'd1;
				next_shift = {in_shift[14:0], lane_s[0]};
			end
		endcase
	end

	// bit count saturates past a full write so odd lengths never commit
	assign next_cnt = (bit_cnt >= `WR_BITS) ? `OVER_BITS : bit_cnt + step;
	assign cmd_done = rise & (phase != PH_WR) & (phase != PH_RD) & (next_cnt == `CMD_BITS);

	// value handed out by a read command
	always_comb begin
		unique case (next_shift[7:0])
			`OP_RD_STATUS: rd_value = status_reg;
			`OP_RD_VCFG: rd_value = vcfg;
			`OP_RD_EVCFG: rd_value = evcfg;
			`OP_RD_FLAG: rd_value = flag_reg;
			default: rd_value = 8'h00;
		endcase
	end

	// [R17] sample rising
	// frame sequencing on rising serial edges
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			phase <= PH_IDLE;
			bit_cnt <= 5'd0;
			in_shift <= 16'h0000;
		end else if (!selected) begin
			phase <= PH_IDLE;
			bit_cnt <= 5'd0;
		end else if (rise) begin
			unique case (phase)
				// command byte
				PH_IDLE, PH_CMD: begin
					in_shift <= next_shift;
					bit_cnt <= next_cnt;
					if (next_cnt == `CMD_BITS) begin
						unique case (next_shift[7:0])
							`OP_RD_STATUS, `OP_RD_VCFG, `OP_RD_EVCFG, `OP_RD_FLAG: begin
								phase <= PH_RD;
							end
							default: begin
								phase <= PH_WR;
							end
						endcase
					end else begin
						phase <= PH_CMD;
					end
				end
				// data byte of a write
				PH_WR: begin
					in_shift <= next_shift;
					bit_cnt <= next_cnt;
				end
				// read: input ignored
				PH_RD: begin
					bit_cnt <= bit_cnt;
				end
			endcase
		end
	end

	// write completes at release with exactly one command and one data byte
	assign ser_v_wr = frame_end & (phase == PH_WR) & (bit_cnt == `WR_BITS)
		& (in_shift[15:8] == `OP_WR_VCFG);
	assign ser_ev_wr = frame_end & (phase == PH_WR) & (bit_cnt == `WR_BITS)
		& (in_shift[15:8] == `OP_WR_EVCFG);

	////////////////////////////////////////////////////////////////////////
	// output lanes
	// [R17] drive from falling
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			out_shift <= 8'h00;
			lane_out <= 4'h0;
			lane_oe <= 4'h0;
		end else if (!selected) begin
			// [R03] release when deselected
			lane_oe <= 4'h0;
		end else if (cmd_done) begin
			// load the answer once the command byte is in
			out_shift <= rd_value;
		end else if (fall && phase == PH_RD) begin
			unique case (proto)
				// one bit on the serial output lane
				PROTO_EXT: begin
					lane_out <= {2'b00, out_shift[7], 1'b0};
					lane_oe <= 4'h2;
					out_shift <= {out_shift[6:0], out_shift[7]};
				end
				// two bits on lanes 1:0
				PROTO_DUAL: begin
					lane_out <= {2'b00, out_shift[7:6]};
					lane_oe <= 4'h3;
					out_shift <= {out_shift[5:0], out_shift[7:6]};
				end
				// four bits on lanes 3:0
				PROTO_QUAD: begin
					lane_out <= out_shift[7:4];
					lane_oe <= 4'hF;
					out_shift <= {out_shift[3:0], out_shift[7:4]};
				end
				default: begin
					lane_oe <= 4'h0;
				end
			endcase
		end
	end

	////////////////////////////////////////////////////////////////////////
	// apb decode
	assign setup = psel & ~penable;
	assign apb_wr = psel & penable & pready & pwrite;
	assign boot_req = apb_wr & (paddr == `OFF_CTRL) & pwdata[`CTRL_BOOT_BIT];
	assign rescue_req = apb_wr & (paddr == `OFF_CTRL) & pwdata[`CTRL_RESCUE_BIT];

	// serial write wins a same-cycle clash with apb
	assign v_wr = ser_v_wr | (apb_wr & (paddr == `OFF_VCFG));
	assign ev_wr = ser_ev_wr | (apb_wr & (paddr == `OFF_EVCFG));
	assign v_wdata = ser_v_wr ? in_shift[7:0] : pwdata[7:0];
	assign ev_wdata = ser_ev_wr ? in_shift[7:0] : pwdata[7:0];

	// [R13] register set
	always_comb begin
		hit = 1'b1;
		rd_mux = 32'h00000000;
		unique case (paddr)
			`OFF_STATUS: rd_mux = {24'h000000, status_reg};
			`OFF_NVCFG: rd_mux = {16'h0000, nvcfg};
			`OFF_VCFG: rd_mux = {24'h000000, vcfg};
			`OFF_EVCFG: rd_mux = {24'h000000, evcfg};
			`OFF_FLAG: rd_mux = {24'h000000, flag_reg};
			`OFF_LOCK: rd_mux = {24'h000000, lock_reg};
			`OFF_CTRL: rd_mux = 32'h00000000;
			`OFF_PROTO: rd_mux = {30'h00000000, proto};
			default: hit = 1'b0;
		endcase
	end

	// answer registered in setup, ready in the first access cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			pready <= 1'b0;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
		end else begin
			pready <= setup;
			pslverr <= setup & ~hit;
			if (setup) begin
				prdata <= pwrite ? 32'h00000000 : rd_mux;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// plain user registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			status_reg <= `RST_STATUS;
			flag_reg <= `RST_FLAG;
			lock_reg <= `RST_LOCK;
		end else if (apb_wr) begin
			if (paddr == `OFF_STATUS) begin
				status_reg <= pwdata[7:0];
			end
			if (paddr == `OFF_FLAG) begin
				flag_reg <= pwdata[7:0];
			end
			if (paddr == `OFF_LOCK) begin
				lock_reg <= pwdata[7:0];
			end
		end
	end

	// [R11] nonvolatile holds choice
	// only an explicit write or presetn changes it; reboot and rescue leave it alone
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			nvcfg <= `RST_NVCFG;
		end else if (apb_wr && paddr == `OFF_NVCFG) begin
			nvcfg <= pwdata[15:0];
		end
	end

	// [R08] volatile lost at boot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			vcfg <= `RST_VCFG;
		end else if (boot_req) begin
			vcfg <= `RST_VCFG;
		end else if (v_wr) begin
			vcfg <= v_wdata;
		end
	end

	// enhanced volatile register, rescue restores its protocol bits
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			evcfg <= `RST_EVCFG;
		end else if (boot_req) begin
			evcfg <= `RST_EVCFG;
		end else if (rescue_req) begin
			evcfg[`EV_QUAD_BIT] <= 1'b1;
			evcfg[`EV_DUAL_BIT] <= 1'b1;
		end else if (ev_wr) begin
			evcfg <= ev_wdata;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// working configuration
	// reload pending after reset release or a software reboot
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			boot_pend <= 1'b1;
		end else begin
			boot_pend <= boot_req;
		end
	end

	// [R14] working protocol, also readable at OFF_PROTO
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			proto <= PROTO_EXT;
		end else if (boot_pend) begin
			// [R15] load from nonvolatile
			if (!nvcfg[`NV_QUAD_BIT]) begin
				// [R12] boot four lanes
				proto <= PROTO_QUAD;
			end else if (!nvcfg[`NV_DUAL_BIT]) begin
				// [R10] boot two lanes
				proto <= PROTO_DUAL;
			end else begin
				proto <= PROTO_EXT;
			end
		end else if (rescue_req) begin
			// [R09] rescue to default
			proto <= PROTO_EXT;
		end else if (ev_wr) begin
			// [R16] copy at once
			if (!ev_wdata[`EV_QUAD_BIT]) begin
				// [R18] four lanes first
				proto <= PROTO_QUAD;
			end else if (!ev_wdata[`EV_DUAL_BIT]) begin
				// [R06] two lanes
				proto <= PROTO_DUAL;
			end else begin
				// [R09] new write to default
				proto <= PROTO_EXT;
			end
		end
	end

	// protocol output mirrors the working configuration
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_proto <= PROTO_EXT;
		end else begin
			active_proto <= proto;
		end
	end

endmodule // multi_io_protocol_config

/* File: sim/mio_chk_sva.sv */
/* checker on the top ports: apb answers, lane enables, protocol hold.
 * assumes it is bound into multi_io_protocol_config. */
`timescale 1ns/1ns
module mio_chk (
	// clock and reset
	input wire logic pclk,
	input wire logic presetn,
	// apb
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr,
	// serial side
	input wire logic cs_n_pin,
	input wire logic [3:0] lane_oe,
	input wire mio_pkg::proto_t active_proto
);
	import mio_pkg::*;
	default clocking @(posedge pclk); endclocking
	default disable iff (!presetn);
	apb_ready_a:
		assert property (psel && !penable |=> pready) else $error("no ready after setup");
	ready_gap_a:
		assert property (!(psel && penable) |-> !pready) else $error("stray ready");
	slv_err_a:
		assert property (pready |-> pslverr == (paddr[7:5] != 3'h0 || paddr[1:0] != 2'h0))
		else $error("error flag wrong");
	err_zero_a:
		assert property (pready && pslverr && !pwrite |-> prdata == 32'h0) else $error("bad data");
	oe_idle_a:
		assert property (cs_n_pin [*8] |-> lane_oe == 4'h0) else $error("lane driven idle");
	oe_sel_a:
		assert property ($rose(|lane_oe) |-> !cs_n_pin) else $error("drive while unselected");
	ext_lane_a:
		assert property (active_proto == PROTO_EXT |-> (lane_oe & 4'hD) == 4'h0)
		else $error("extended lane misuse");
	dual_lane_a:
		assert property (active_proto == PROTO_DUAL |-> lane_oe[3:2] == 2'h0)
		else $error("dual lane misuse");
	proto_hold_a:
		assert property ((!cs_n_pin && !psel) [*4] |=> $stable(active_proto))
		else $error("protocol moved");
endmodule // mio_chk

bind multi_io_protocol_config mio_chk u_chk (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .paddr(paddr), .prdata(prdata), .pready(pready),
	.pslverr(pslverr), .cs_n_pin(cs_n_pin), .lane_oe(lane_oe), .active_proto(active_proto));

/* File: sim/ser_master.sv */
/* serial bus master model: chip select, serial clock and lane drive.
 * assumes the device needs eight pclk per sclk half period. */
`timescale 1ns/1ns
module ser_master (
	// clock
	input wire logic pclk,
	// serial pins
	output logic cs_n,
	output logic sclk,
	output logic [3:0] lane_in,
	input wire logic [3:0] lane_out,
	input wire logic [3:0] lane_oe
);
	localparam int HALF = 8; // pclk per half period
	initial begin
		cs_n = 1'b1;
		sclk = 1'b0;
		lane_in = 4'hC;
	end
	// one 16 bit frame, w lanes a clock; rd samples the w lanes after the command
	task automatic frame(input logic c, input int w, input logic [15:0] wd,
		input logic rd, output logic [7:0] got);
		logic [15:0] t;
		logic [3:0] n;
		logic [3:0] o;
		sclk <= c;
		repeat (HALF) @(posedge pclk);
		cs_n <= 1'b0;
		repeat (HALF) @(posedge pclk);
		for (int i = 0; i < 16; i += w) begin
			t = wd << i;
			n = t[15:12] >> (4 - w);
			sclk <= 1'b0;
			lane_in <= w == 4 ? n : {2'b11, w == 2 ? n[1] : ~lane_in[1], n[0]};
			repeat (HALF) @(posedge pclk);
			o = ~(lane_out ^ lane_oe);
			// extended answers on lane1 only, dual on lanes 1:0, quad on 3:0
			if (rd && i >= 8)
				for (int b = w - 1; b >= 0; b--)
					got = {got[6:0], o[w == 1 ? 1 : b]};
			sclk <= 1'b1;
			repeat (HALF) @(posedge pclk);
		end
		sclk <= c;
		repeat (HALF) @(posedge pclk);
		cs_n <= 1'b1;
		// released lanes flip
		lane_in <= ~lane_in;
		repeat (HALF) @(posedge pclk);
	endtask
endmodule // ser_master

/* File: sim/testbench.sv */
/* bench: apb and serial traffic against a small behavioural model.
 * assumes the ser_master model and the bound checker. */
`timescale 1ns/1ns
`include "mio_cfg.svh"
module testbench;
	import mio_pkg::*;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, cs_n, sclk, err;
	logic [7:0] paddr, got;
	logic [31:0] pwdata, prdata, rd;
	logic [3:0] lane_in, lane_out, lane_oe;
	proto_t active_proto;
	int n_mismatch, n_tests, ev, vc, p, i, v;
	int rx[4];
	logic [7:0] adr[6] = '{`OFF_STATUS, `OFF_NVCFG, `OFF_VCFG, `OFF_EVCFG, `OFF_FLAG, `OFF_LOCK};
	int rst[6] = '{`RST_STATUS, `RST_NVCFG, `RST_VCFG, `RST_EVCFG, `RST_FLAG, `RST_LOCK};
	logic [7:0] evs[9] = '{8'hBF, 8'hFF, 8'h7F, 8'h3F, 8'hBF, 8'h7F, 8'hFF, 8'hBF, 8'hFF};
	logic [7:0] rop[4] = '{`OP_RD_VCFG, `OP_RD_EVCFG, `OP_RD_STATUS, `OP_RD_FLAG};
	logic [15:0] nvs[5] = '{16'hFFFB, 16'hFFF7, 16'hFFF3, 16'hFFF3, 16'hFFFF};
	logic [8:0] cpl = 9'h0B4; // clock mode per serial enhanced write
	multi_io_protocol_config dut (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr), .cs_n_pin(cs_n), .sclk_pin(sclk),
		.lane_in(lane_in), .lane_out(lane_out), .lane_oe(lane_oe), .active_proto(active_proto));
	ser_master master (.pclk(pclk), .cs_n(cs_n), .sclk(sclk), .lane_in(lane_in),
		.lane_out(lane_out), .lane_oe(lane_oe));
	initial begin
		pclk = 1'b0;
		forever #5 pclk = ~pclk;
	end
	// lane protocol from two select bits, q wins
	function automatic int pr(input logic [15:0] c, input int q, input int d);
		return !c[q] ? 2 : !c[d] ? 1 : 0;
	endfunction
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		n_tests++;
		if (g !== e) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, g, e);
		end
	endtask
	task automatic chk_p();
		repeat (4) @(posedge pclk);
		n_tests++;
		if (active_proto !== 2'(p)) begin
			n_mismatch++;
			$display("BAD %0t %h %h", $time, active_proto, p);
		end
	endtask
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// wait for ready as long as it takes, the watchdog ends a hang
		do
			@(posedge pclk);
		while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		@(posedge pclk);
	endtask
	task automatic rchk(input logic [7:0] a, input int e);
		apb(1'b0, a, 32'h0);
		chk(rd, e);
	endtask
	task automatic finish_test();
		if (n_mismatch == 0 && n_tests > 0)
			$display("DONE - PASS");
		else
			$display("DONE - FAIL");
		$finish;
	endtask
	// watchdog
	initial begin
		repeat (40000) @(posedge pclk);
		n_mismatch++;
		finish_test();
	end
	initial begin
		void'($urandom(6609));
		{presetn, psel, penable, pwrite, paddr, pwdata} = '0;
		repeat (4) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		for (i = 0; i < 6; i++)
			rchk(adr[i], rst[i]);
		chk_p();
		apb(1'b0, 8'h20, 32'h0);
		chk({rd[30:0], err}, 1);
		rchk(`OFF_PROTO, 0);
		for (i = 0; i < 9; i++) begin
			master.frame(cpl[i], 1 << p, {`OP_WR_EVCFG, evs[i]}, 1'b0, got);
			repeat (10) @(posedge pclk);
			ev = evs[i];
			p = pr(16'(ev), 7, 6);
			chk_p();
			rchk(`OFF_EVCFG, ev);
		end
		vc = $urandom % 256;
		master.frame(1'b1, 1, {`OP_WR_VCFG, 8'(vc)}, 1'b0, got);
		repeat (10) @(posedge pclk);
		rchk(`OFF_VCFG, vc);
		rx = '{vc, ev, `RST_STATUS, `RST_FLAG};
		for (i = 0; i < 4; i++) begin
			master.frame(i[0], 1, {rop[i], 8'h00}, 1'b1, got);
			chk(got, rx[i]);
		end
		// read answers on two and four lanes, protocol set over apb first
		for (i = 0; i < 2; i++) begin
			v = i ? 8'h7F : 8'hBF;
			apb(1'b1, `OFF_EVCFG, v);
			master.frame(i[0], i ? 4 : 2, {`OP_RD_EVCFG, 8'h00}, 1'b1, got);
			chk(got, v);
		end
		for (i = 0; i < 7; i++) begin
			v = i == 6 ? 8'h7F : $urandom % 256;
			apb(1'b1, `OFF_EVCFG, v);
			p = pr(16'(v), 7, 6);
			chk_p();
		end
		apb(1'b1, `OFF_CTRL, 1 << `CTRL_RESCUE_BIT);
		p = 0;
		chk_p();
		rchk(`OFF_EVCFG, 8'hFF);
		for (i = 0; i < 5; i++) begin
			apb(1'b1, `OFF_NVCFG, nvs[i]);
			apb(1'b1, `OFF_EVCFG, 8'h3F);
			apb(1'b1, `OFF_CTRL, 1 << `CTRL_BOOT_BIT);
			p = pr(nvs[i], 3, 2);
			chk_p();
			rchk(`OFF_EVCFG, `RST_EVCFG);
		end
		apb(1'b1, `OFF_EVCFG, 8'h7F);
		presetn <= 1'b0;
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		p = 0;
		chk_p();
		rchk(`OFF_EVCFG, `RST_EVCFG);
		finish_test();
	end
endmodule // testbench
